// ---- hw/aim_pkg.sv ----
// Constants and types for the advanced antenna-carrier IQ mapper.
// Assumes one core clock shared by frame datapath and user logic.
//
// What this block does
// - Decode mode codes 01, 10, 11.
// - Each sample its own container; consecutive slots allowed.
// - No sample crosses a basic frame boundary.
// - Unclaimed spare bits are reserved, frame end.
// - One entry each shown at selected index.
// - Entry: enable, antenna-carrier, position, width.
// - Start offset in bits from starting slot.
// - Width field honoured up to 16, ignored in packed 15-bit use; spill or second sample.
// - Packed 15-bit modes identical; entry position still applied, so gaps possible.
// - Only data bytes form the timeslot stream.
// - Incomplete trailing slots dropped or reserved.
// - Mode 11 with 16-bit width refused.
// - Entries beyond line rate and K unavailable.
// - New 15-bit mode allows nonzero offsets.
// - Outside packed 15-bit use, each entry sets its own sample width.
package aim_pkg;
  localparam logic [1:0] MODE_NEW_IQ   = 2'h1;
  localparam logic [1:0] MODE_BACKCOMP = 2'h2;
  localparam logic [1:0] MODE_ORIG_IQ  = 2'h3;
  localparam int         IDX_W         = 6;
  localparam int         TABLE_DEPTH   = 64;
  localparam int         AXC_W         = 4;
  localparam int         TS_W          = 32;
  localparam int         FIFO_DEPTH    = 16;
  localparam logic [4:0] PACKED_WIDTH  = 5'h0F;
  localparam logic [4:0] MAX_WIDTH     = 5'h10;
  localparam logic [5:0] TS_BITS       = 6'h20;
  localparam logic [7:0] K_RESET       = 8'h01;
  localparam logic [5:0] SLOT_RESET    = 6'h00;

  typedef struct packed {
    logic             en;
    logic [AXC_W-1:0] axc;
    logic [4:0]       pos;
    logic [4:0]       width;
  } aim_entry_t;

  typedef struct packed {
    logic [AXC_W-1:0] axc;
    logic [TS_W-1:0]  data;
  } aim_sample_t;

  typedef struct packed {
    logic [7:0] k;
    logic [5:0] frame_slots;
  } aim_setup_t;

  localparam aim_entry_t ENTRY_RESET = '0;
endpackage

// ---- hw/aim_mapper.sv ----
// Advanced IQ mapper: slot position counter, sample FIFO and top.
// Assumes the frame side presents data-byte timeslots only.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Sample FIFO
// ----------------------------------------
module aim_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  wire              push = i_valid && o_ready;
  wire              pop  = o_valid && i_ready;

  assign o_ready = (cnt_reg != DEPTH[AW:0]);
  assign o_valid = (cnt_reg != '0);
  assign o_data  = mem_reg[rd_reg];

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= push ? AW'(wr_reg + 1'b1) : wr_reg;
      rd_reg  <= pop ? AW'(rd_reg + 1'b1) : rd_reg;
      cnt_reg <= (AW+1)'(cnt_reg + push - pop);
    end
  end
endmodule

// ----------------------------------------
// Table index of the current timeslot
// ----------------------------------------
module aim_slot_pos (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_reset,
  input  wire logic                   i_step,
  input  wire logic                   i_first,
  input  wire aim_pkg::aim_setup_t    i_setup,
  output logic [aim_pkg::IDX_W-1:0]   o_idx,
  output logic                        o_avail
);
  logic [7:0]  frame_reg;
  logic [5:0]  slot_reg;
  logic        started_reg;
  wire  [7:0]  frame_inc = 8'(frame_reg + 1'b1);
  wire  [7:0]  wrap_frame = (frame_inc >= i_setup.k) ? 8'h00 : frame_inc;
  wire  [7:0]  cur_frame = i_first ? (started_reg ? wrap_frame : 8'h00) : frame_reg;
  wire  [5:0]  cur_slot = i_first ? 6'h00 : slot_reg;
  wire  [15:0] flat = 16'(cur_frame * i_setup.frame_slots) + 16'(cur_slot);

  assign o_idx   = flat[aim_pkg::IDX_W-1:0];
  // Slots past the table or past the frame carry nothing
  assign o_avail = (flat < 16'(aim_pkg::TABLE_DEPTH)) && (cur_slot < i_setup.frame_slots)
                   && (started_reg || i_first);

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      frame_reg   <= 8'h00;
      slot_reg    <= aim_pkg::SLOT_RESET;
      started_reg <= 1'b0;
    end else if (i_step) begin
      frame_reg   <= cur_frame;
      slot_reg    <= 6'(cur_slot + 1'b1);
      started_reg <= started_reg || i_first;
    end
  end
endmodule

// ----------------------------------------
// Top
// ----------------------------------------
module aim_mapper #(
  parameter int FIFO_DEPTH = aim_pkg::FIFO_DEPTH
) (
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_reset,
  input  wire logic [1:0]                   i_map_mode,
  input  wire logic                         i_width_16bit,
  input  wire aim_pkg::aim_setup_t          i_mapping_table_setup_reg,
  input  wire logic [aim_pkg::IDX_W-1:0]    i_map_entry_select_reg,
  input  wire logic                         i_rx_entry_wr,
  input  wire aim_pkg::aim_entry_t          i_rx_entry_data,
  input  wire logic                         i_tx_entry_wr,
  input  wire aim_pkg::aim_entry_t          i_tx_entry_data,
  output aim_pkg::aim_entry_t               o_rx_entry_window_reg,
  output aim_pkg::aim_entry_t               o_tx_entry_window_reg,
  output logic                              o_mode_unsupported,
  input  wire logic                         i_tx_sample_valid,
  output logic                              o_tx_sample_ready,
  input  wire aim_pkg::aim_sample_t         i_tx_sample,
  input  wire logic                         i_tx_ts_req,
  input  wire logic                         i_tx_ts_first,
  output logic [aim_pkg::TS_W-1:0]          o_tx_ts_word,
  output logic                              o_tx_ts_valid,
  output logic                              o_tx_underrun,
  input  wire logic                         i_rx_ts_valid,
  input  wire logic                         i_rx_ts_first,
  input  wire logic [aim_pkg::TS_W-1:0]     i_rx_ts_word,
  output aim_pkg::aim_sample_t              o_rx_sample,
  output logic                              o_rx_sample_valid
);
  aim_pkg::aim_entry_t rx_table_reg [aim_pkg::TABLE_DEPTH];
  aim_pkg::aim_entry_t tx_table_reg [aim_pkg::TABLE_DEPTH];

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire mode_new    = (i_map_mode == aim_pkg::MODE_NEW_IQ);
  wire mode_packed = (i_map_mode == aim_pkg::MODE_BACKCOMP) ||
                     (i_map_mode == aim_pkg::MODE_ORIG_IQ);
  wire mode_bad    = !(mode_new || mode_packed) ||
                     (i_map_mode == aim_pkg::MODE_ORIG_IQ && i_width_16bit);
  wire force_pack  = mode_packed && !i_width_16bit;
  assign o_mode_unsupported = mode_bad;

  // Width per entry, capped at 16; packed modes without 16-bit width force 15
  function automatic logic [5:0] eff_bits(input logic [4:0] w, input logic pack);
    logic [4:0] c;
    c = pack ? aim_pkg::PACKED_WIDTH : ((w > aim_pkg::MAX_WIDTH) ? aim_pkg::MAX_WIDTH : w);
    return {c, 1'b0};
  endfunction

  function automatic logic [63:0] bit_mask(input logic [5:0] n);
    return 64'((65'h1 << n) - 1'b1);
  endfunction

  // ----------------------------------------
  // Table access
  // ----------------------------------------
  assign o_rx_entry_window_reg = rx_table_reg[i_map_entry_select_reg];
  assign o_tx_entry_window_reg = tx_table_reg[i_map_entry_select_reg];

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < aim_pkg::TABLE_DEPTH; i++) begin
        rx_table_reg[i] <= aim_pkg::ENTRY_RESET;
        tx_table_reg[i] <= aim_pkg::ENTRY_RESET;
      end
    end else begin
      if (i_rx_entry_wr) begin
        rx_table_reg[i_map_entry_select_reg] <= i_rx_entry_data;
      end
      if (i_tx_entry_wr) begin
        tx_table_reg[i_map_entry_select_reg] <= i_tx_entry_data;
      end
    end
  end

  // ----------------------------------------
  // Tx: samples to timeslots
  // ----------------------------------------
  logic [aim_pkg::IDX_W-1:0] tx_idx;
  logic                      tx_avail;
  logic                      fifo_valid;
  aim_pkg::aim_sample_t      fifo_head;
  logic [31:0]               tx_carry_reg;

  aim_slot_pos u_tx_pos (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_step    (i_tx_ts_req),
    .i_first   (i_tx_ts_first),
    .i_setup   (i_mapping_table_setup_reg),
    .o_idx     (tx_idx),
    .o_avail   (tx_avail)
  );

  wire aim_pkg::aim_entry_t tx_e = tx_table_reg[tx_idx];
  wire [5:0]  tx_bits   = eff_bits(tx_e.width, force_pack);
  wire        tx_want   = i_tx_ts_req && tx_avail && tx_e.en && !mode_bad;
  wire        tx_pop    = tx_want && fifo_valid && (fifo_head.axc == tx_e.axc);
  wire [63:0] tx_shift  = (64'(fifo_head.data) & bit_mask(tx_bits)) << tx_e.pos;
  wire [31:0] tx_base   = i_tx_ts_first ? 32'h0000_0000 : tx_carry_reg;
  // Unclaimed bits stay zero as reserved
  wire [31:0] tx_word   = tx_base | (tx_pop ? tx_shift[31:0] : 32'h0000_0000);
  wire [31:0] tx_spill  = tx_pop ? tx_shift[63:32] : 32'h0000_0000;

  aim_fifo #(
    .WIDTH ($bits(aim_pkg::aim_sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_valid   (i_tx_sample_valid),
    .o_ready   (o_tx_sample_ready),
    .i_data    (i_tx_sample),
    .o_valid   (fifo_valid),
    .i_ready   (tx_pop),
    .o_data    (fifo_head)
  );

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_carry_reg  <= 32'h0000_0000;
      o_tx_ts_word  <= 32'h0000_0000;
      o_tx_ts_valid <= 1'b0;
      o_tx_underrun <= 1'b0;
    end else begin
      o_tx_ts_valid <= i_tx_ts_req;
      o_tx_underrun <= tx_want && !tx_pop;
      if (i_tx_ts_req) begin
        o_tx_ts_word <= tx_word;
        tx_carry_reg <= tx_spill;
      end
    end
  end

  // ----------------------------------------
  // Rx: timeslots to samples
  // ----------------------------------------
  logic [aim_pkg::IDX_W-1:0] rx_idx;
  logic                      rx_avail;
  logic                      pend_reg;
  logic [31:0]               part_reg;
  logic [5:0]                part_shift_reg;
  logic [5:0]                part_bits_reg;
  logic [aim_pkg::AXC_W-1:0] part_axc_reg;

  aim_slot_pos u_rx_pos (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_step    (i_rx_ts_valid),
    .i_first   (i_rx_ts_first),
    .i_setup   (i_mapping_table_setup_reg),
    .o_idx     (rx_idx),
    .o_avail   (rx_avail)
  );

  wire aim_pkg::aim_entry_t rx_e = rx_table_reg[rx_idx];
  wire [5:0]  rx_bits  = eff_bits(rx_e.width, force_pack);
  wire [6:0]  rx_end   = 7'(rx_e.pos) + 7'(rx_bits);
  wire        rx_spill = (rx_end > 7'(aim_pkg::TS_BITS));
  wire        rx_cont  = i_rx_ts_valid && pend_reg && !i_rx_ts_first;
  wire        rx_start = i_rx_ts_valid && !rx_cont && rx_avail && rx_e.en && !mode_bad;
  wire [31:0] rx_field = i_rx_ts_word >> rx_e.pos;
  wire [31:0] rx_join  = 32'((64'(part_reg) | (64'(i_rx_ts_word) << part_shift_reg))
                             & bit_mask(part_bits_reg));
  wire [31:0] rx_whole = 32'(64'(rx_field) & bit_mask(rx_bits));

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      pend_reg          <= 1'b0;
      part_reg          <= 32'h0000_0000;
      part_shift_reg    <= 6'h00;
      part_bits_reg     <= 6'h00;
      part_axc_reg      <= '0;
      o_rx_sample       <= '0;
      o_rx_sample_valid <= 1'b0;
    end else begin
      o_rx_sample_valid <= rx_cont || (rx_start && !rx_spill);
      if (rx_cont) begin
        o_rx_sample <= '{axc: part_axc_reg, data: rx_join};
      end else if (rx_start && !rx_spill) begin
        o_rx_sample <= '{axc: rx_e.axc, data: rx_whole};
      end
      if (i_rx_ts_valid) begin
        pend_reg <= rx_start && rx_spill;
      end
      if (rx_start && rx_spill) begin
        part_reg       <= rx_field;
        part_shift_reg <= 6'(aim_pkg::TS_BITS - 6'(rx_e.pos));
        part_bits_reg  <= rx_bits;
        part_axc_reg   <= rx_e.axc;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  mode_refuse_a: assert property (mode_bad |-> !tx_pop && !rx_start)
    else $error("refused mode moved data");
  tx_slot_out_a: assert property (i_tx_ts_req |=> o_tx_ts_valid)
    else $error("timeslot word missing");
  tx_frame_clean_a: assert property (i_tx_ts_req && i_tx_ts_first && !tx_pop |=> o_tx_ts_word == 32'h0)
    else $error("spill crossed frame");
  tx_unavail_a: assert property (i_tx_ts_req && !tx_avail |-> !tx_pop)
    else $error("unavailable slot used");
  tx_disabled_a: assert property (!tx_e.en |-> !tx_pop)
    else $error("disabled entry used");
  packed_width_a: assert property (force_pack |-> tx_bits == 6'h1E && rx_bits == 6'h1E)
    else $error("packed width not 30");
  rx_window_a: assert property (i_rx_entry_wr ##1 $stable(i_map_entry_select_reg)
                                |-> o_rx_entry_window_reg == $past(i_rx_entry_data))
    else $error("rx window stale");
  tables_apart_a: assert property (i_tx_entry_wr && !i_rx_entry_wr ##1 $stable(i_map_entry_select_reg)
                                   |-> $stable(o_rx_entry_window_reg))
    else $error("tx write hit rx table");
  rx_emit_a: assert property (rx_start && !rx_spill |=> o_rx_sample_valid && o_rx_sample.axc == $past(rx_e.axc))
    else $error("rx sample not emitted");
  rx_frame_a: assert property (i_rx_ts_valid && i_rx_ts_first && !rx_start |=> !o_rx_sample_valid)
    else $error("rx sample crossed frame");

  tx_spill_c: cover property (tx_pop && tx_spill != 32'h0);
  rx_join_c: cover property (rx_cont);
  fifo_full_c: cover property (!o_tx_sample_ready);
  underrun_c: cover property (o_tx_underrun);
endmodule

`default_nettype wire

// ---- tb/aim_frame_model.sv ----
// Frame-side model: requests Tx timeslots and presents Rx timeslots.
// Assumes one core clock; every call starts just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module aim_frame_model (
  input  wire logic                     i_ref_clk,
  output logic                          o_tx_req,
  output logic                          o_tx_first,
  output logic                          o_rx_valid,
  output logic                          o_rx_first,
  output logic [aim_pkg::TS_W-1:0]      o_rx_word
);
  initial begin
    o_tx_req   = 1'b0;
    o_tx_first = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_first = 1'b0;
    o_rx_word  = 32'hA5A5_0F0F;
  end

  // Whole data slots only, first flagged per basic frame
  task automatic tx_frame(input int n);
    for (int i = 0; i < n; i++) begin
      o_tx_req   = 1'b1;
      o_tx_first = (i == 0);
      @(posedge i_ref_clk);
      #1;
    end
    o_tx_req   = 1'b0;
    o_tx_first = 1'b0;
  endtask

  task automatic rx_frame(input logic [31:0] w [4]);
    for (int i = 0; i < 4; i++) begin
      o_rx_valid = 1'b1;
      o_rx_first = (i == 0);
      o_rx_word  = w[i];
      @(posedge i_ref_clk);
      #1;
    end
    o_rx_valid = 1'b0;
    o_rx_first = 1'b0;
    // Released data line never keeps its last value
    o_rx_word  = ~o_rx_word;
  endtask
endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the advanced IQ mapper.
// Assumes aim_pkg and the mapper files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                        i_ref_clk;
  logic                        i_reset;
  logic [1:0]                  i_map_mode;
  logic                        i_width_16bit;
  aim_pkg::aim_setup_t         i_mapping_table_setup_reg;
  logic [5:0]                  i_map_entry_select_reg;
  logic                        i_rx_entry_wr;
  aim_pkg::aim_entry_t         i_rx_entry_data;
  logic                        i_tx_entry_wr;
  aim_pkg::aim_entry_t         i_tx_entry_data;
  aim_pkg::aim_entry_t         o_rx_entry_window_reg;
  aim_pkg::aim_entry_t         o_tx_entry_window_reg;
  logic                        o_mode_unsupported;
  logic                        i_tx_sample_valid;
  logic                        o_tx_sample_ready;
  aim_pkg::aim_sample_t        i_tx_sample;
  logic                        i_tx_ts_req;
  logic                        i_tx_ts_first;
  logic [31:0]                 o_tx_ts_word;
  logic                        o_tx_ts_valid;
  logic                        o_tx_underrun;
  logic                        i_rx_ts_valid;
  logic                        i_rx_ts_first;
  logic [31:0]                 i_rx_ts_word;
  aim_pkg::aim_sample_t        o_rx_sample;
  logic                        o_rx_sample_valid;
  logic [35:0]                 tx_q [$];
  logic [35:0]                 rx_q [$];
  logic [35:0]                 un_q [$];
  logic [31:0]                 s [3];
  logic [31:0]                 w [4];
  aim_pkg::aim_entry_t         re;
  aim_pkg::aim_entry_t         te;
  int                          err_count = 0;
  int                          n_checks  = 0;

  aim_mapper #(.FIFO_DEPTH(16)) DUT (
    .i_ref_clk                 (i_ref_clk),
    .i_reset                   (i_reset),
    .i_map_mode                (i_map_mode),
    .i_width_16bit             (i_width_16bit),
    .i_mapping_table_setup_reg (i_mapping_table_setup_reg),
    .i_map_entry_select_reg    (i_map_entry_select_reg),
    .i_rx_entry_wr             (i_rx_entry_wr),
    .i_rx_entry_data           (i_rx_entry_data),
    .i_tx_entry_wr             (i_tx_entry_wr),
    .i_tx_entry_data           (i_tx_entry_data),
    .o_rx_entry_window_reg     (o_rx_entry_window_reg),
    .o_tx_entry_window_reg     (o_tx_entry_window_reg),
    .o_mode_unsupported        (o_mode_unsupported),
    .i_tx_sample_valid         (i_tx_sample_valid),
    .o_tx_sample_ready         (o_tx_sample_ready),
    .i_tx_sample               (i_tx_sample),
    .i_tx_ts_req               (i_tx_ts_req),
    .i_tx_ts_first             (i_tx_ts_first),
    .o_tx_ts_word              (o_tx_ts_word),
    .o_tx_ts_valid             (o_tx_ts_valid),
    .o_tx_underrun             (o_tx_underrun),
    .i_rx_ts_valid             (i_rx_ts_valid),
    .i_rx_ts_first             (i_rx_ts_first),
    .i_rx_ts_word              (i_rx_ts_word),
    .o_rx_sample               (o_rx_sample),
    .o_rx_sample_valid         (o_rx_sample_valid)
  );

  aim_frame_model m (
    .i_ref_clk  (i_ref_clk),
    .o_tx_req   (i_tx_ts_req),
    .o_tx_first (i_tx_ts_first),
    .o_rx_valid (i_rx_ts_valid),
    .o_rx_first (i_rx_ts_first),
    .o_rx_word  (i_rx_ts_word)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [35:0] exp, input logic [35:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic cmp_entry(input string what, input aim_pkg::aim_entry_t exp, input aim_pkg::aim_entry_t got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask

  function automatic aim_pkg::aim_entry_t ent(logic en, logic [3:0] a, logic [4:0] p, logic [4:0] wd);
    ent = {en, a, p, wd};
  endfunction

  task automatic wr_entry(input logic rx, input logic [5:0] idx, input aim_pkg::aim_entry_t e);
    i_map_entry_select_reg = idx;
    i_rx_entry_wr          = rx;
    i_tx_entry_wr          = !rx;
    i_rx_entry_data        = e;
    i_tx_entry_data        = e;
    @(posedge i_ref_clk);
    #1;
    i_rx_entry_wr = 1'b0;
    i_tx_entry_wr = 1'b0;
    @(posedge i_ref_clk);
    #1;
  endtask

  task automatic chk_win(input logic [5:0] idx, input aim_pkg::aim_entry_t er, input aim_pkg::aim_entry_t et);
    i_map_entry_select_reg = idx;
    #1;
    cmp_entry("rx window", er, o_rx_entry_window_reg);
    cmp_entry("tx window", et, o_tx_entry_window_reg);
    @(posedge i_ref_clk);
    #1;
  endtask

  task automatic push_sample(input logic [31:0] d);
    int i;
    i_tx_sample       = {4'h2, d};
    i_tx_sample_valid = 1'b1;
    for (i = 0; i < 50 && o_tx_sample_ready !== 1'b1; i++) begin
      @(posedge i_ref_clk);
      #1;
    end
    if (i == 50) begin
      cmp("sample ready", 36'h1, 36'h0);
      results();
    end
    @(posedge i_ref_clk);
    #1;
    i_tx_sample_valid = 1'b0;
    @(posedge i_ref_clk);
    #1;
  endtask

  task automatic drain(input string name);
    for (int i = 0; i < 100 && (tx_q.size() + rx_q.size() + un_q.size()) > 0; i++)
      @(posedge i_ref_clk);
    #1;
    if (tx_q.size() + rx_q.size() + un_q.size() > 0) begin
      cmp("pending results", 36'h0, 36'(tx_q.size() + rx_q.size() + un_q.size()));
      results();
    end
    $display("test %s done", name);
  endtask

  // Results side: oldest expectation against each output pulse
  always @(negedge i_ref_clk) begin
    if (o_tx_ts_valid === 1'b1)
      cmp("tx word", tx_q.size() ? tx_q.pop_front() : 'x, {4'h0, o_tx_ts_word});
    if (o_rx_sample_valid === 1'b1)
      cmp("rx sample", rx_q.size() ? rx_q.pop_front() : 'x, o_rx_sample);
    if (o_tx_underrun === 1'b1)
      cmp("tx underrun", un_q.size() ? un_q.pop_front() : 'x, 36'h1);
  end

  initial begin
    i_reset                   = 1'b1;
    i_map_mode                = 2'h1;
    i_width_16bit             = 1'b0;
    i_mapping_table_setup_reg = {8'h01, 6'h04};
    i_map_entry_select_reg    = 6'h00;
    i_rx_entry_wr             = 1'b0;
    i_rx_entry_data           = '0;
    i_tx_entry_wr             = 1'b0;
    i_tx_entry_data           = '0;
    i_tx_sample_valid         = 1'b0;
    i_tx_sample               = '0;
    void'($urandom(32'h6b12));
    repeat (2) @(posedge i_ref_clk);
    #1;
    i_reset = 1'b0;
    for (int i = 0; i < 4; i++) begin
      re = aim_pkg::aim_entry_t'($urandom);
      te = aim_pkg::aim_entry_t'($urandom);
      wr_entry(1'b1, 6'(10 + i), re);
      chk_win(6'(10 + i), re, '0);
      wr_entry(1'b0, 6'(10 + i), te);
      chk_win(6'(10 + i), re, te);
    end
    $display("test tables done");
    for (int k = 0; k < 8; k++) begin
      i_map_mode    = 2'(k >> 1);
      i_width_16bit = k[0];
      #1;
      cmp("unsupported", 36'((k >> 1) == 0 || k == 7), {35'h0, o_mode_unsupported});
      @(posedge i_ref_clk);
      #1;
    end
    $display("test modes done");
    i_width_16bit = 1'b0;
    wr_entry(1'b0, 6'h00, ent(1'b1, 4'h2, 5'h00, 5'h10));
    wr_entry(1'b0, 6'h01, ent(1'b0, 4'h2, 5'h00, 5'h10));
    wr_entry(1'b0, 6'h02, ent(1'b1, 4'h2, 5'h01, 5'h0F));
    wr_entry(1'b0, 6'h03, ent(1'b1, 4'h2, 5'h00, 5'h0F));
    for (int md = 1; md < 4; md++) begin
      i_map_mode = 2'(md);
      for (int i = 0; i < 3; i++)
        s[i] = $urandom;
      tx_q.push_back({4'h0, (md == 1) ? s[0] : s[0] & 32'h3FFF_FFFF});
      tx_q.push_back(36'h0);
      tx_q.push_back({4'h0, (s[1] & 32'h3FFF_FFFF) << 1});
      tx_q.push_back({4'h0, s[2] & 32'h3FFF_FFFF});
      tx_q.push_back(36'h0);
      for (int i = 0; i < 3; i++)
        push_sample(s[i]);
      m.tx_frame(5);
      drain("tx frame");
    end
    for (int i = 0; i < 5; i++)
      tx_q.push_back(36'h0);
    for (int i = 0; i < 3; i++)
      un_q.push_back(36'h1);
    m.tx_frame(5);
    drain("tx underrun");
    i_map_mode    = 2'h1;
    i_width_16bit = 1'b1;
    wr_entry(1'b0, 6'h00, ent(1'b1, 4'h2, 5'h04, 5'h10));
    for (int i = 0; i < 3; i++)
      s[i] = $urandom;
    tx_q.push_back({4'h0, s[0] << 4});
    tx_q.push_back({4'h0, 28'h0, s[0][31:28]});
    tx_q.push_back({4'h0, (s[1] & 32'h3FFF_FFFF) << 1});
    tx_q.push_back({4'h0, s[2] & 32'h3FFF_FFFF});
    tx_q.push_back(36'h0);
    for (int i = 0; i < 3; i++)
      push_sample(s[i]);
    m.tx_frame(5);
    drain("tx spill");
    wr_entry(1'b1, 6'h00, ent(1'b1, 4'h5, 5'h04, 5'h10));
    wr_entry(1'b1, 6'h01, ent(1'b1, 4'h5, 5'h00, 5'h10));
    wr_entry(1'b1, 6'h02, ent(1'b1, 4'h6, 5'h00, 5'h08));
    wr_entry(1'b1, 6'h03, ent(1'b0, 4'h6, 5'h00, 5'h08));
    for (int i = 0; i < 4; i++)
      w[i] = $urandom;
    rx_q.push_back({4'h5, w[1][3:0], w[0][31:4]});
    rx_q.push_back({4'h6, 16'h0, w[2][15:0]});
    m.rx_frame(w);
    drain("rx frame");
    results();
  end
endmodule

`default_nettype wire
